/* hw/cawd_pkg.sv */
// Constants shared by the counter array watchdog design
package cawd_pkg;

	// Register index on the plain register port
	localparam logic [3:0] OFF_CTRL   = 4'h0; // counter_ctrl_reg
	localparam logic [3:0] OFF_MODE   = 4'h1; // counter mode register
	localparam logic [3:0] OFF_LOW    = 4'h2; // counter_low_byte
	localparam logic [3:0] OFF_HIGH   = 4'h3; // counter_high_byte
	localparam logic [3:0] OFF_M2MODE = 4'h4; // module2_mode_reg
	localparam logic [3:0] OFF_OFFSET = 4'h5; // wdt_offset_reg
	localparam logic [3:0] OFF_CMPH   = 4'h6; // wdt_compare_high
	localparam logic [3:0] OFF_WDCTRL = 4'h7; // watchdog enable register

	// Field positions
	localparam int BIT_RUN       = 6; // counter_run in counter_ctrl_reg
	localparam int BIT_MATCH     = 2; // module2_match_flag in counter_ctrl_reg
	localparam int BIT_IDLE_HALT = 7; // counter_idle_halt in mode register
	localparam int SEL_LSB       = 1; // counter_clk_select low bit
	localparam int SEL_MSB       = 3; // counter_clk_select high bit
	localparam int BIT_ECOM      = 6; // comparator enable in module2 mode
	localparam int BIT_MAT       = 3; // match enable in module2 mode
	localparam int BIT_WD_EN     = 0; // watchdog enable

	// Reset values
	localparam logic [7:0] RST_REG   = 8'h00;
	localparam logic       RST_WD_EN = 1'b0;

	// Module2 mode forced while the watchdog runs: software timer
	localparam logic [7:0] M2_SW_TIMER = 8'h48;

	// Clock source prescalers, in system clocks
	localparam logic [3:0] DIV_SLOW = 4'hC; // clock / 12
	localparam logic [3:0] DIV_FAST = 4'h4; // clock / 4

	// Clock source codes of counter_clk_select
	localparam logic [2:0] SRC_DIV12 = 3'h0;
	localparam logic [2:0] SRC_DIV4  = 3'h1;
	localparam logic [2:0] SRC_EXT   = 3'h2;
	localparam logic [2:0] SRC_SYS   = 3'h4;

endpackage

/* hw/cawd_counter_array_watchdog.sv */
// Counter array with watchdog on compare module 2
//
// Implementation choices: the address-and-strobe port and the register offsets.

// Register map on the plain port, one byte per index:
//   0 control: counter run in bit 6, module 2 match flag in bit 2
//   1 counter mode: idle halt in bit 7, clock source in bits 3 to 1
//   2 counter low byte, 3 counter high byte
//   4 module 2 mode, 5 watchdog offset, 6 watchdog compare high
//   7 watchdog enable in bit 0, writable at any time
// Read data stand for one cycle after the read strobe and are zero
// otherwise. Locked registers swallow writes without any error, so
// software that needs certainty reads back. The reset request is not
// looped back inside this block: the system reset logic must pull
// reset_n low, and that is what clears the watchdog.

module cawd_counter_array_watchdog (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       cpu_idle,
	input  wire logic       ext_tick,
	output logic            wdt_reset
);

	// Register hit decode used for both write and read paths
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	logic [7:0] low;
	logic [7:0] high;
	logic [7:0] offset;
	logic [7:0] cmph;
	logic [7:0] m2_mode;
	logic       run;
	logic       match_flag;
	logic       idle_halt;
	logic [2:0] clk_sel;
	logic       wd_en;
	logic [3:0] div_cnt;

	// Write strobes per register
	wire wr_ctrl   = wr && hit(addr, cawd_pkg::OFF_CTRL);
	wire wr_mode   = wr && hit(addr, cawd_pkg::OFF_MODE);
	wire wr_low    = wr && hit(addr, cawd_pkg::OFF_LOW);
	wire wr_high   = wr && hit(addr, cawd_pkg::OFF_HIGH);
	wire wr_m2     = wr && hit(addr, cawd_pkg::OFF_M2MODE);
	wire wr_offset = wr && hit(addr, cawd_pkg::OFF_OFFSET);
	wire wr_cmph   = wr && hit(addr, cawd_pkg::OFF_CMPH);
	wire wr_wdctrl = wr && hit(addr, cawd_pkg::OFF_WDCTRL);

	// Prescaler enables; the slow period is a multiple of the fast one,
	// so one divider serves both sources and no second counter is needed
	wire tick_slow = (div_cnt == cawd_pkg::DIV_SLOW - 4'h1);
	wire tick_fast = ((div_cnt % cawd_pkg::DIV_FAST)
		== cawd_pkg::DIV_FAST - 4'h1);

	// Clock source selection; unlisted codes fall back to system clock
	wire src_tick =
		(clk_sel == cawd_pkg::SRC_DIV12) ? tick_slow :
		(clk_sel == cawd_pkg::SRC_DIV4)  ? tick_fast :
		(clk_sel == cawd_pkg::SRC_EXT)   ? ext_tick  : 1'b1;

	// Watchdog forces the run state; software bit is only stored
	wire run_eff = wd_en | run;
	wire halted  = idle_halt & cpu_idle;
	wire tick    = run_eff & ~halted & src_tick;

	// Module 2 reads as software timer while the watchdog owns it
	wire [7:0] m2_eff = wd_en ? cawd_pkg::M2_SW_TIMER : m2_mode;
	wire       m2_swt = m2_eff[cawd_pkg::BIT_ECOM] & m2_eff[cawd_pkg::BIT_MAT];

	// Overflow of the low byte is the watchdog's unit of time
	wire low_ovf   = tick & (low == 8'hFF);
	wire high_eq   = (high == cmph);
	wire time_out  = wd_en & low_ovf & high_eq;
	wire force_rst = wd_en & wr_ctrl & wdata[cawd_pkg::BIT_MATCH];
	// Guard keeps a second request from stretching the pulse
	wire next_wdt_reset = (time_out | force_rst) & ~wdt_reset;

	// Software timer match only counts while the watchdog is off
	wire match_set = ~wd_en & m2_swt & tick & ({high, low} == {cmph, offset});
	wire next_match = match_set
		| (wr_ctrl ? (wdata[cawd_pkg::BIT_MATCH] & ~wd_en) : match_flag);

	// Counter bytes; a dropped write still lets the tick through
	wire [7:0] next_low  = (wr_low & ~wd_en) ? wdata :
		(tick ? 8'(low + 8'h01) : low);
	wire [7:0] next_high = (wr_high & ~wd_en) ? wdata :
		(low_ovf ? 8'(high + 8'h01) : high);
	// Refresh loads a fresh deadline instead of the written value
	wire [7:0] next_cmph = ~wr_cmph ? cmph :
		(wd_en ? 8'(high + offset) : wdata);

	// Readback images; run shows the stored bit, not the forced state
	wire [7:0] ctrl_rd = {1'b0, run, 3'h0, match_flag, 2'h0};
	wire [7:0] mode_rd = {idle_halt, 3'h0, clk_sel, 1'b0};
	wire [7:0] next_rdata =
		hit(addr, cawd_pkg::OFF_CTRL)   ? ctrl_rd :
		hit(addr, cawd_pkg::OFF_MODE)   ? mode_rd :
		hit(addr, cawd_pkg::OFF_LOW)    ? low :
		hit(addr, cawd_pkg::OFF_HIGH)   ? high :
		hit(addr, cawd_pkg::OFF_M2MODE) ? m2_eff :
		hit(addr, cawd_pkg::OFF_OFFSET) ? offset :
		hit(addr, cawd_pkg::OFF_CMPH)   ? cmph :
		hit(addr, cawd_pkg::OFF_WDCTRL) ? {7'h00, wd_en} : 8'h00;

	// Prescaler; it runs while the counter is stopped too, spending a
	// little power so that starting the counter needs no resync
	always_ff @(posedge clock)
	begin
		if (!reset_n || tick_slow)
			div_cnt <= 4'h0;
		else
			div_cnt <= div_cnt + 4'h1;
	end

	// Counter and compare registers
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			low    <= cawd_pkg::RST_REG;
			high   <= cawd_pkg::RST_REG;
			cmph   <= cawd_pkg::RST_REG;
			offset <= cawd_pkg::RST_REG;
		end
		else
		begin
			low    <= next_low;
			high   <= next_high;
			cmph   <= next_cmph;
			offset <= wr_offset ? wdata : offset;
		end
	end

	// Control bits; the locked ones only move while the watchdog is off
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			run        <= 1'b0;
			match_flag <= 1'b0;
			idle_halt  <= 1'b0;
			clk_sel    <= cawd_pkg::SRC_DIV12;
			m2_mode    <= cawd_pkg::RST_REG;
			wd_en      <= cawd_pkg::RST_WD_EN;
		end
		else
		begin
			run        <= wr_ctrl ? wdata[cawd_pkg::BIT_RUN] : run;
			match_flag <= next_match;
			if (wr_mode && !wd_en)
			begin
				idle_halt <= wdata[cawd_pkg::BIT_IDLE_HALT];
				clk_sel   <= wdata[cawd_pkg::SEL_MSB:cawd_pkg::SEL_LSB];
			end
			if (wr_m2 && !wd_en)
				m2_mode <= wdata;
			if (wr_wdctrl)
				wd_en <= wdata[cawd_pkg::BIT_WD_EN];
		end
	end

	// Read data and the reset request, both registered outputs
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			rdata     <= cawd_pkg::RST_REG;
			wdt_reset <= 1'b0;
		end
		else
		begin
			rdata     <= rd ? next_rdata : 8'h00;
			wdt_reset <= next_wdt_reset;
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_counter_forced_on: assert property (
		wd_en && src_tick && !halted |-> tick)
		else $error("counter not running with watchdog on");
	a_low_write_blocked: assert property (
		wd_en && wr_low && !tick |=> low == $past(low))
		else $error("low byte changed by write under watchdog");
	a_high_write_blocked: assert property (
		wd_en && wr_high && !low_ovf |=> high == $past(high))
		else $error("high byte changed by write under watchdog");
	a_select_frozen: assert property (
		wd_en && wr_mode |=> $stable(clk_sel) && $stable(idle_halt))
		else $error("clock select changed under watchdog");
	a_mode2_locked: assert property (
		wd_en && wr_m2 |=> $stable(m2_mode)
			&& m2_eff == cawd_pkg::M2_SW_TIMER)
		else $error("module2 mode not locked");
	a_run_write_held: assert property (
		wd_en && wr_ctrl && !wdata[cawd_pkg::BIT_RUN]
			&& !wr_wdctrl |=> run_eff)
		else $error("run write stopped counter");
	a_run_reads_zero: assert property (
		rd && hit(addr, cawd_pkg::OFF_CTRL) && wd_en && !run
			|=> !rdata[cawd_pkg::BIT_RUN])
		else $error("run bit read as set");
	a_timeout_reset: assert property (
		wd_en && low == 8'hFF && tick && high == cmph && !wdt_reset
			|=> wdt_reset)
		else $error("missed watchdog timeout");
	a_refresh_load: assert property (
		wd_en && wr_cmph |=> cmph == 8'($past(high) + $past(offset)))
		else $error("refresh loaded wrong deadline");
	a_force_reset: assert property (
		force_rst && !wdt_reset |=> wdt_reset)
		else $error("forced reset missing");
	a_reset_single: assert property (
		wdt_reset |=> !wdt_reset)
		else $error("reset pulse longer than one cycle");
	a_reset_cause: assert property (
		$rose(wdt_reset) |-> $past(wd_en))
		else $error("reset without watchdog enabled");

	c_refresh: cover property (wd_en && wr_cmph);
	c_timeout: cover property (time_out);
	c_forced: cover property (force_rst);
	c_match_set: cover property (match_set);
	c_run_held: cover property (wd_en && wr_ctrl
		&& !wdata[cawd_pkg::BIT_RUN]);

	// Stronger forms of the checks above. Apart from a_source_held,
	// a_deadline_held, a_flag_not_set, a_timeout_match and a_reset_has_cause, they pin down the exact next value rather than
	// mere stability, so a lock that leaks one tick late or early is caught as well.

	// Every enabled source tick moves the low byte by one
	a_timer_ticks: assert property (
		wd_en && src_tick && !halted
			|=> low == 8'($past(low) + 8'h01))
		else $error("counter missed a tick under watchdog");

	// A low byte overflow wraps to zero and steps the high byte
	a_overflow_step: assert property (
		wd_en && low_ovf
			|=> low == 8'h00 && high == 8'($past(high) + 8'h01))
		else $error("overflow did not step the high byte");

	// A dropped high byte write leaves only the overflow step
	a_high_only_ovf: assert property (
		wd_en && wr_high
			|=> high == 8'($past(high) + {7'h00, $past(low_ovf)}))
		else $error("high byte write leaked under watchdog");

	// Clock source and idle halt hold still for the whole enabled time
	a_source_held: assert property (
		wd_en |=> $stable(clk_sel) && $stable(idle_halt))
		else $error("clock source moved under watchdog");

	// Module 2 mode reads as software timer while enabled
	a_mode2_reads: assert property (
		rd && hit(addr, cawd_pkg::OFF_M2MODE) && wd_en
			|=> rdata == cawd_pkg::M2_SW_TIMER)
		else $error("module2 mode read wrong under watchdog");

	// The run bit keeps whatever software wrote, forced or not
	a_run_stored: assert property (
		wr_ctrl |=> run == $past(wdata[cawd_pkg::BIT_RUN]))
		else $error("run bit not stored as written");

	// A disabled watchdog never asks for a reset
	a_quiet_disabled: assert property (
		!wd_en |=> !wdt_reset)
		else $error("reset request with watchdog off");

	// The deadline only moves on a refresh
	a_deadline_held: assert property (
		wd_en && !wr_cmph |=> $stable(cmph))
		else $error("deadline moved without refresh");

	// A timeout pulse comes from a high byte match on an overflow
	a_timeout_match: assert property (
		wdt_reset && !$past(force_rst)
			|-> $past(high) == $past(cmph) && $past(low_ovf))
		else $error("timeout without high byte match");

	// Under the watchdog a match flag write cannot raise the flag
	a_flag_not_set: assert property (
		wd_en |=> !$rose(match_flag))
		else $error("match flag set under watchdog");

	// Every pulse has a cause in the cycle before it
	a_reset_has_cause: assert property (
		wdt_reset |-> $past(time_out || force_rst))
		else $error("reset pulse without a cause");

endmodule // cawd_counter_array_watchdog

/* bench/tb_counter_array_watchdog.sv */
// Self-checking bench for the counter array watchdog
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_counter_array_watchdog;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, reset_n, wr, rd, cpu_idle, ext_tick, wdt_reset;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata, v, h, k, l, l1;
	logic [31:0] seed = 32'h35BF;
	int          n_errors = 0, checked = 0, n;

	cawd_counter_array_watchdog dut (.clock(clock), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.cpu_idle(cpu_idle), .ext_tick(ext_tick), .wdt_reset(wdt_reset));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Clock, 10 ns period
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Toggling side inputs catch a halt or source lock that leaks;
	// they rest low in reset so that this block is their only driver
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			cpu_idle <= 1'b0;
			ext_tick <= 1'b0;
		end
		else
		begin
			cpu_idle <= ~cpu_idle;
			ext_tick <= ~ext_tick;
		end
	end

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Counter clocks from the read of the low byte to the pulse: the
	// rest of this low byte, then one full low byte per offset step
	function automatic int exp_timeout(input logic [7:0] off,
		input logic [7:0] lo);
		return 256 * off + 255 - lo;
	endfunction

	// Deadline loaded by a refresh, wrapping like the 8-bit register
	function automatic logic [7:0] exp_deadline(input logic [7:0] hi,
		input logic [7:0] off);
		return 8'(hi + off);
	endfunction

	// Reset is driven on a rising edge even when called off the edge
	task automatic do_reset();
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (11) @(posedge clock);
		reset_n <= 1'b1;
	endtask

	initial
	begin
		{reset_n, wr, rd, addr, wdata} = '0;
		for (int r = 0; r < 4; r++)
		begin
			do_reset();
			h = 8'(rnd());
			k = 8'(rnd() % 32'h3);
			l = (r == 0) ? 8'h00 : 8'(rnd() % 32'hC0);
			rreg(cawd_pkg::OFF_CMPH, v);
			`CHK("cmph reset", 8'h00, v)
			rreg(4'(32'h8 + rnd() % 32'h8), v);
			`CHK("unmapped", 8'h00, v)
			// Watchdog off: counter bytes writable, match write harmless
			wreg(cawd_pkg::OFF_LOW, l);
			wreg(cawd_pkg::OFF_HIGH, h);
			rreg(cawd_pkg::OFF_LOW, v);
			`CHK("low off", l, v)
			wreg(cawd_pkg::OFF_CTRL, 8'h04);
			#1 `CHK("no force off", 1'b0, wdt_reset)
			wreg(cawd_pkg::OFF_OFFSET, k);
			wreg(cawd_pkg::OFF_MODE, 8'h08); // System clock source
			wreg(cawd_pkg::OFF_WDCTRL, 8'h01);
			wreg(cawd_pkg::OFF_CMPH, 8'(rnd()));
			// Locked writes while enabled
			wreg(cawd_pkg::OFF_HIGH, ~h);
			wreg(cawd_pkg::OFF_LOW, 8'hFF);
			wreg(cawd_pkg::OFF_MODE, 8'h80);
			wreg(cawd_pkg::OFF_M2MODE, 8'h00);
			wreg(cawd_pkg::OFF_CTRL, 8'h00);
			rreg(cawd_pkg::OFF_CMPH, v);
			`CHK("refresh", exp_deadline(h, k), v)
			rreg(cawd_pkg::OFF_HIGH, v);
			`CHK("high locked", h, v)
			rreg(cawd_pkg::OFF_MODE, v);
			`CHK("mode frozen", 8'h08, v)
			rreg(cawd_pkg::OFF_M2MODE, v);
			`CHK("m2 mode", cawd_pkg::M2_SW_TIMER, v)
			rreg(cawd_pkg::OFF_CTRL, v);
			`CHK("run reads 0", 8'h00, v & 8'h40)
			rreg(cawd_pkg::OFF_LOW, l1);
			`CHK("running", 1'b1, l1 > l)
			// Edges from the low read to the reset pulse
			n = 0;
			while (wdt_reset !== 1'b1)
			begin
				@(posedge clock);
				#1;
				n++;
				if (n > 1100)
				begin
					n_errors++;
					$display("CHECK FAILED timeout exp pulse got none");
					end_of_test();
				end
			end
			`CHK("timeout", exp_timeout(k, l1), n)
			@(posedge clock);
			#1 `CHK("pulse width", 1'b0, wdt_reset)
			// Disabled with run clear: the counter must stop
			wreg(cawd_pkg::OFF_WDCTRL, 8'h00);
			rreg(cawd_pkg::OFF_LOW, v);
			rreg(cawd_pkg::OFF_LOW, l1);
			`CHK("stopped", v, l1)
			// Forced reset through the match flag
			do_reset();
			wreg(cawd_pkg::OFF_WDCTRL, 8'h01);
			rreg(cawd_pkg::OFF_LOW, v);
			`CHK("cleared", 8'h00, v)
			wreg(cawd_pkg::OFF_CTRL, 8'h04);
			#1 `CHK("forced", 1'b1, wdt_reset)
			@(posedge clock);
			#1 `CHK("forced width", 1'b0, wdt_reset)
			$display("round %0d done, offset %0d", r, k);
		end
		end_of_test();
	end
endmodule // tb_counter_array_watchdog
